// File: esp_pkg.sv
// Constants for the enhanced serial port: register map, fields, resets, timing.
// Assumes a byte-wide special-function register port on the system clock.
package esp_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] ESP_PWR_CTRL = 8'h87;
  localparam logic [7:0] ESP_AUX_CFG = 8'h8E;
  localparam logic [7:0] ESP_WAKE_CLOCKOUT_CTRL = 8'h8F;
  localparam logic [7:0] ESP_SER_CTRL = 8'h98;
  localparam logic [7:0] ESP_SER_BUF = 8'h99;
  localparam logic [7:0] ESP_BAUD_RELOAD = 8'h9C;
  localparam logic [7:0] ESP_AUX_CFG2 = 8'hA2;
  localparam logic [7:0] ESP_IRQ_EN = 8'hA8;
  localparam logic [7:0] ESP_SLV_ADDR = 8'hA9;
  localparam logic [7:0] ESP_IRQ_PRIO = 8'hB8;
  localparam logic [7:0] ESP_SLV_MASK = 8'hB9;
  // ==========================================
  // Reset values
  localparam logic [7:0] ESP_PWR_RST = 8'h10;
  localparam logic [7:0] ESP_ZERO_RST = 8'h00;
  localparam logic [7:0] ESP_AUX2_RST = 8'h00;
  // ==========================================
  // Field positions
  localparam int ESP_SC_MODE0 = 7;
  localparam int ESP_SC_MODE1 = 6;
  localparam int ESP_SC_MPEN = 5;
  localparam int ESP_SC_REN = 4;
  localparam int ESP_SC_TB8 = 3;
  localparam int ESP_SC_RB8 = 2;
  localparam int ESP_SC_TI = 1;
  localparam int ESP_SC_RI = 0;
  localparam int ESP_PC_DOUBLE = 7;
  localparam int ESP_PC_FESEL = 6;
  localparam int ESP_AX_T1SPD = 6;
  localparam int ESP_AX_M0SPD = 5;
  localparam int ESP_AX_BRUN = 4;
  localparam int ESP_AX_BSPD = 2;
  localparam int ESP_AX_BSRC = 0;
  // ==========================================
  // Timing counts: prescaler and shift periods in system clocks, bit phases and sample points in oversample ticks
  localparam logic [3:0] ESP_PRESCALE_12 = 4'd12;
  localparam logic [3:0] ESP_SHIFT_SLOW = 4'd12;
  localparam logic [3:0] ESP_SHIFT_FAST = 4'd2;
  localparam logic [4:0] ESP_MODE2_TICK = 5'd2;
  localparam logic [3:0] ESP_OVERSAMPLE = 4'd15;
  localparam logic [3:0] ESP_SAMPLE_A = 4'd7;
  localparam logic [3:0] ESP_SAMPLE_B = 4'd8;
  localparam logic [3:0] ESP_SAMPLE_C = 4'd9;
  // Serial mode encodings
  typedef enum logic [1:0] {
    ESP_MODE_SHIFT = 2'b00,
    ESP_MODE_UART8 = 2'b01,
    ESP_MODE_UART9F = 2'b10,
    ESP_MODE_UART9V = 2'b11
  } esp_mode_e;
endpackage : esp_pkg

// File: esp_reload_counter.sv
// 8-bit up counter with reload on overflow, used for timer 1 and the baud generator.
// Assumes tick is a single-cycle enable from the same clock.
`timescale 1ns/1ps
`default_nettype none
module esp_reload_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic start,
  input wire logic tick,
  input wire logic [WIDTH-1:0] reload,
  output logic overflow
);
  logic [WIDTH-1:0] count;
  // ==========================================
  // Counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (start) begin
      count <= reload;
    end else if (run && tick) begin
      if (&count) begin
        count <= reload;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
  assign overflow = run && tick && (&count);
endmodule : esp_reload_counter
`default_nettype wire

// File: esp_serial_port.sv
// Enhanced serial port: registers, baud sources, transmitter and receiver.
// Assumes a single-cycle byte register port and a serial line from outside.
`timescale 1ns/1ps
`default_nettype none
module esp_serial_port
  import esp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] timer1_reload,
  input wire logic timer1_run,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);
  import esp_pkg::*;
  // ==========================================
  // Registers
  logic [7:0] power_control, aux_config, wake_clockout_ctrl, serial_control;
  logic [7:0] baud_reload, aux_config_second, irq_enable, irq_priority;
  logic [7:0] slave_address, slave_address_mask, rx_buffer, tx_hold;
  logic framing_error_flag, mode_bit_zero;
  logic wr_ctrl, wr_buf, rd_any, set_ti, set_ri, set_rb8, rb8_val, set_fe;
  logic [1:0] mode;
  logic [7:0] rx_data;
  assign wr_ctrl = sfr_wr && sfr_addr == ESP_SER_CTRL;
  assign wr_buf = sfr_wr && sfr_addr == ESP_SER_BUF;
  assign rd_any = sfr_rd;
  assign mode = {mode_bit_zero, serial_control[ESP_SC_MODE1]};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_control <= ESP_PWR_RST;
      aux_config <= ESP_ZERO_RST;
      wake_clockout_ctrl <= ESP_ZERO_RST;
      baud_reload <= ESP_ZERO_RST;
      aux_config_second <= ESP_AUX2_RST;
      irq_enable <= ESP_ZERO_RST;
      irq_priority <= ESP_ZERO_RST;
      slave_address <= ESP_ZERO_RST;
      slave_address_mask <= ESP_ZERO_RST;
      tx_hold <= ESP_ZERO_RST;
    end else if (sfr_wr) begin
      case (sfr_addr)
        ESP_PWR_CTRL: power_control <= sfr_wdata;
        ESP_AUX_CFG: aux_config <= sfr_wdata;
        ESP_WAKE_CLOCKOUT_CTRL: wake_clockout_ctrl <= sfr_wdata;
        ESP_BAUD_RELOAD: baud_reload <= sfr_wdata;
        ESP_AUX_CFG2: aux_config_second <= sfr_wdata;
        ESP_IRQ_EN: irq_enable <= sfr_wdata;
        ESP_IRQ_PRIO: irq_priority <= sfr_wdata;
        ESP_SLV_ADDR: slave_address <= sfr_wdata;
        ESP_SLV_MASK: slave_address_mask <= sfr_wdata;
        ESP_SER_BUF: tx_hold <= sfr_wdata;
        default: ;
      endcase
    end
  end
  // Serial control: hardware sets win over software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_control <= ESP_ZERO_RST;
      mode_bit_zero <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        serial_control[6:3] <= sfr_wdata[6:3];
        if (!power_control[ESP_PC_FESEL]) begin
          mode_bit_zero <= sfr_wdata[ESP_SC_MODE0];
        end
      end
      serial_control[ESP_SC_RB8] <= set_rb8 ? rb8_val :
        (wr_ctrl ? sfr_wdata[ESP_SC_RB8] : serial_control[ESP_SC_RB8]);
      serial_control[ESP_SC_TI] <= set_ti ||
        (wr_ctrl ? sfr_wdata[ESP_SC_TI] : serial_control[ESP_SC_TI]);
      serial_control[ESP_SC_RI] <= set_ri ||
        (wr_ctrl ? sfr_wdata[ESP_SC_RI] : serial_control[ESP_SC_RI]);
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      framing_error_flag <= 1'b0;
    end else if (set_fe) begin
      framing_error_flag <= 1'b1;
    end else if (wr_ctrl && power_control[ESP_PC_FESEL]) begin
      framing_error_flag <= sfr_wdata[ESP_SC_MODE0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buffer <= ESP_ZERO_RST;
    end else if (set_ri) begin
      rx_buffer <= rx_data;
    end
  end
  // Read mux
  always_comb begin
    sfr_rdata = 8'h00;
    if (rd_any) begin
      case (sfr_addr)
        ESP_PWR_CTRL: sfr_rdata = power_control;
        ESP_AUX_CFG: sfr_rdata = aux_config;
        ESP_WAKE_CLOCKOUT_CTRL: sfr_rdata = wake_clockout_ctrl;
        ESP_SER_CTRL: sfr_rdata = {power_control[ESP_PC_FESEL] ? framing_error_flag :
                                   mode_bit_zero, serial_control[6:0]};
        ESP_SER_BUF: sfr_rdata = rx_buffer;
        ESP_BAUD_RELOAD: sfr_rdata = baud_reload;
        ESP_AUX_CFG2: sfr_rdata = aux_config_second;
        ESP_IRQ_EN: sfr_rdata = irq_enable;
        ESP_IRQ_PRIO: sfr_rdata = irq_priority;
        ESP_SLV_ADDR: sfr_rdata = slave_address;
        ESP_SLV_MASK: sfr_rdata = slave_address_mask;
        default: sfr_rdata = 8'h00;
      endcase
    end
  end
  // ==========================================
  // Baud sources
  logic [3:0] pre12;
  logic tick12, brun_d, t1_ovf, brg_ovf, sel_ovf;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre12 <= 4'd0;
    end else begin
      pre12 <= (pre12 == ESP_PRESCALE_12 - 4'd1) ? 4'd0 : pre12 + 4'd1;
    end
  end
  assign tick12 = pre12 == ESP_PRESCALE_12 - 4'd1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      brun_d <= 1'b0;
    end else begin
      brun_d <= aux_config[ESP_AX_BRUN];
    end
  end
  esp_reload_counter #(.WIDTH(8)) u_timer1 (
    .clk(clk),
    .arst_n(arst_n),
    .run(timer1_run),
    .start(1'b0),
    .tick(aux_config[ESP_AX_T1SPD] ? 1'b1 : tick12),
    .reload(timer1_reload),
    .overflow(t1_ovf)
  );
  esp_reload_counter #(.WIDTH(8)) u_baud_gen (
    .clk(clk),
    .arst_n(arst_n),
    .run(aux_config[ESP_AX_BRUN]),
    .start(aux_config[ESP_AX_BRUN] && !brun_d),
    .tick(aux_config[ESP_AX_BSPD] ? 1'b1 : tick12),
    .reload(baud_reload),
    .overflow(brg_ovf)
  );
  assign sel_ovf = aux_config[ESP_AX_BSRC] ? brg_ovf : t1_ovf;
  // Sixteenth-bit tick: variable modes divide overflow by 32 or 16, fixed mode clk by 64 or 32
  logic [4:0] pre32;
  logic src_tick, os_tick;
  assign src_tick = mode == ESP_MODE_UART9F ? 1'b1 : sel_ovf;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre32 <= 5'd0;
    end else if (src_tick) begin
      pre32 <= pre32 + 5'd1;
    end
  end
  always_comb begin
    if (mode == ESP_MODE_UART9F) begin
      os_tick = power_control[ESP_PC_DOUBLE] ? pre32[0] : &pre32[1:0];
    end else begin
      os_tick = src_tick && (power_control[ESP_PC_DOUBLE] || pre32[0]);
    end
  end
  // Shift mode clock tick
  logic [3:0] shdiv, sh_half;
  logic sh_tick;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shdiv <= 4'd0;
    end else begin
      shdiv <= sh_tick ? 4'd0 : shdiv + 4'd1;
    end
  end
  // Tick each half shift period, so one data bit per divide count
  assign sh_half = (aux_config[ESP_AX_M0SPD] ? ESP_SHIFT_FAST : ESP_SHIFT_SLOW) >> 1;
  assign sh_tick = shdiv == sh_half - 4'd1;
  // ==========================================
  // Input synchroniser
  logic rx_s1, rx_s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rxd_in;
      rx_s2 <= rx_s1;
    end
  end
  // ==========================================
  // Transmitter
  logic [3:0] tx_phase;
  logic [3:0] tx_bits;
  logic [9:0] tx_shift;
  logic tx_busy, tx_req, sh_clk_hi;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy <= 1'b0;
      tx_req <= 1'b0;
      tx_phase <= 4'd0;
      tx_bits <= 4'd0;
      tx_shift <= 10'h3FF;
      txd_out <= 1'b1;
      sh_clk_hi <= 1'b1;
    end else begin
      if (wr_buf) begin
        tx_req <= 1'b1;
      end
      if (!tx_busy) begin
        txd_out <= 1'b1;
        if (tx_req && (mode == ESP_MODE_SHIFT ? sh_tick : os_tick)) begin
          tx_req <= wr_buf;
          tx_busy <= 1'b1;
          tx_phase <= 4'd0;
          if (mode == ESP_MODE_SHIFT) begin
            tx_shift <= {2'b11, tx_hold};
            tx_bits <= 4'd8;
          end else if (mode == ESP_MODE_UART8) begin
            tx_shift <= {1'b1, 1'b1, tx_hold};
            tx_bits <= 4'd10;
            txd_out <= 1'b0;
          end else begin
            tx_shift <= {1'b1, serial_control[ESP_SC_TB8], tx_hold};
            tx_bits <= 4'd11;
            txd_out <= 1'b0;
          end
        end
      end else if (mode == ESP_MODE_SHIFT) begin
        if (sh_tick) begin
          sh_clk_hi <= !sh_clk_hi;
          if (sh_clk_hi) begin
            txd_out <= 1'b0;
          end else begin
            txd_out <= 1'b1;
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bits <= tx_bits - 4'd1;
            if (tx_bits == 4'd1) begin
              tx_busy <= 1'b0;
            end
          end
        end
      end else if (os_tick) begin
        tx_phase <= tx_phase + 4'd1;
        if (tx_phase == ESP_OVERSAMPLE) begin
          tx_bits <= tx_bits - 4'd1;
          if (tx_bits == 4'd1) begin
            tx_busy <= 1'b0;
            txd_out <= 1'b1;
          end else begin
            txd_out <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
          end
        end
      end
    end
  end
  assign set_ti = tx_busy && ((mode == ESP_MODE_SHIFT) ?
    (sh_tick && !sh_clk_hi && tx_bits == 4'd1) :
    (os_tick && tx_phase == ESP_OVERSAMPLE && tx_bits == 4'd1));
  assign rxd_out = tx_shift[0];
  assign rxd_oe = tx_busy && mode == ESP_MODE_SHIFT;
  // ==========================================
  // Receiver
  logic [3:0] rx_phase, rx_bits;
  logic [8:0] rx_shift;
  logic [2:0] votes;
  logic rx_busy, rx_prev, bit_val, addr_ok, accept, frame_end, stop_bit;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy <= 1'b0;
      rx_prev <= 1'b1;
      rx_phase <= 4'd0;
      rx_bits <= 4'd0;
      rx_shift <= 9'h000;
      votes <= 3'b111;
    end else begin
      if (os_tick) begin
        rx_prev <= rx_s2;
      end
      if (!serial_control[ESP_SC_REN] || mode == ESP_MODE_SHIFT) begin
        rx_busy <= 1'b0;
      end else if (!rx_busy) begin
        if (os_tick && rx_prev && !rx_s2) begin
          rx_busy <= 1'b1;
          rx_phase <= 4'd0;
          rx_bits <= (mode == ESP_MODE_UART8) ? 4'd10 : 4'd11;
        end
      end else if (os_tick) begin
        rx_phase <= rx_phase + 4'd1;
        if (rx_phase == ESP_SAMPLE_A) votes[0] <= rx_s2;
        if (rx_phase == ESP_SAMPLE_B) votes[1] <= rx_s2;
        if (rx_phase == ESP_SAMPLE_C) votes[2] <= rx_s2;
        if (rx_phase == ESP_OVERSAMPLE) begin
          rx_bits <= rx_bits - 4'd1;
          if (rx_bits == ((mode == ESP_MODE_UART8) ? 4'd10 : 4'd11) && bit_val) begin
            rx_busy <= 1'b0;
          end else if (rx_bits == 4'd1) begin
            rx_busy <= 1'b0;
          end else begin
            rx_shift <= {bit_val, rx_shift[8:1]};
          end
        end
      end
    end
  end
  assign bit_val = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
  assign frame_end = rx_busy && os_tick && rx_phase == ESP_OVERSAMPLE && rx_bits == 4'd1;
  assign stop_bit = bit_val;
  assign rx_data = (mode == ESP_MODE_UART8) ? rx_shift[8:1] : rx_shift[7:0];
  assign addr_ok = ((rx_data ^ slave_address) & slave_address_mask) == 8'h00 ||
                   ((rx_data | ~(slave_address | slave_address_mask)) == 8'hFF);
  always_comb begin
    if (!serial_control[ESP_SC_MPEN]) begin
      accept = 1'b1;
    end else if (mode == ESP_MODE_UART8) begin
      accept = stop_bit && addr_ok;
    end else begin
      accept = rx_shift[8] && addr_ok;
    end
  end
  // One byte lost if RI is still set from the previous one
  assign set_ri = frame_end && !serial_control[ESP_SC_RI] && accept;
  assign set_rb8 = set_ri;
  assign rb8_val = (mode == ESP_MODE_UART8) ? stop_bit : rx_shift[8];
  assign set_fe = frame_end && !stop_bit;
endmodule : esp_serial_port
`default_nettype wire

// File: esp_serial_port_checker.sv
// Concurrent checks on the serial port register port and line outputs.
// Assumes binding to esp_serial_port; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module esp_serial_port_checker
  import esp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Write then read back on the same address
  property p_back(logic [7:0] a, logic [7:0] m);
    sfr_wr && sfr_addr == a ##1 sfr_rd && sfr_addr == a
      |-> (sfr_rdata & m) == ($past(sfr_wdata) & m);
  endproperty
  a_idle_read_zero: assert property (!sfr_rd |-> sfr_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h00 |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reload_back: assert property (p_back(ESP_BAUD_RELOAD, 8'hFF))
    else $error("baud reload readback wrong");
  a_slave_back: assert property (p_back(ESP_SLV_ADDR, 8'hFF))
    else $error("slave address readback wrong");
  a_mask_back: assert property (p_back(ESP_SLV_MASK, 8'hFF))
    else $error("slave mask readback wrong");
  a_mode_bits_back: assert property (p_back(ESP_SER_CTRL, 8'h78))
    else $error("serial control readback wrong");
  a_double_back: assert property (p_back(ESP_PWR_CTRL, 8'hC0))
    else $error("power control readback wrong");
  a_baud_cfg_back: assert property (p_back(ESP_AUX_CFG, 8'h75))
    else $error("aux config readback wrong");
  // ==========================================
  // Line output
  a_start_bit_low: assert property ($fell(txd_out) && !rxd_oe |-> !txd_out [*8])
    else $error("start bit too short");
  c_frame: cover property ($fell(txd_out) && !rxd_oe);
  c_shift: cover property ($rose(rxd_oe));
  c_rx_flag: cover property (sfr_rd && sfr_addr == ESP_SER_CTRL && sfr_rdata[0]);
endmodule : esp_serial_port_checker
bind esp_serial_port esp_serial_port_checker u_chk (
  .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rxd_oe(rxd_oe), .txd_out(txd_out)
);
`default_nettype wire

// File: esp_line_peer.sv
// Remote serial device on the line: sends frames, captures transmitted ones.
// Assumes the bench sets bit_clks and nine; bit_clks of 0 mutes capture.
`timescale 1ns/1ps
`default_nettype none
module esp_line_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bit_clks = 32;
  logic nine = 1'b0;
  logic [8:0] got = '0;
  int n_got = 0;
  int start_len = 0;
  initial rxd = 1'b1;
  // ==========================================
  // Start 0, data LSB first, ninth bit when nine is set, stop
  task automatic send(input logic [8:0] d, input logic stop);
    int n;
    logic [10:0] f;
    f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    n = nine ? 11 : 10;
    @(posedge clk);
    for (int b = 0; b < n; b++) begin
      rxd <= f[b];
      repeat (bit_clks) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
  // ==========================================
  // Capture: start length, then mid-bit samples
  always begin : watch
    @(negedge txd);
    if (bit_clks > 0) begin
      got = '0;
      start_len = 0;
      @(negedge clk);
      while (!txd) begin
        start_len++;
        @(negedge clk);
      end
      repeat (bit_clks / 2) @(negedge clk);
      for (int b = 0; b < (nine ? 9 : 8); b++) begin
        got[b] = txd;
        repeat (bit_clks) @(negedge clk);
      end
      n_got++;
    end
  end
endmodule : esp_line_peer
`default_nettype wire

// File: test_esp_serial_port.sv
// Self-checking bench for the serial port: registers, baud paths, frames.
// Assumes esp_line_peer on the serial pins and the package constants.
`timescale 1ns/1ps
`default_nettype none
module test_esp_serial_port;
  import esp_pkg::*;
  logic clk, arst_n, sfr_wr, sfr_rd, rxd_in, rxd_out, rxd_oe, txd_out;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, s;
  int n_fail = 0;
  int n_compared = 0;
  int i, j, k;
  time t0;
  logic oe_seen;
  logic [7:0] c_sc [8] = '{8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h98, 8'h98, 8'hD8};
  logic [7:0] c_ax [8] = '{8'h40, 8'h40, 8'h15, 8'h11, 8'h00, 8'h00, 8'h00, 8'h15};
  logic [7:0] c_pc [8] = '{8'h80, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80};
  logic [7:0] c_br [8] = '{8'h00, 8'h00, 8'hFD, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFD};
  int c_bit [8] = '{32, 64, 48, 192, 384, 32, 64, 48};
  logic [7:0] m_sc [8] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h70, 8'h70, 8'h70, 8'h40};
  logic [8:0] m_d [8] = '{9'h1C2, 9'h1C4, 9'h0C0, 9'h1FF, 9'h0C0, 9'h0C0, 9'h0C4, 9'h0C0};
  logic [7:0] m_st = 8'hDF;
  logic [7:0] m_ex = 8'h19;
  logic [7:0] r_a [7] = '{ESP_PWR_CTRL, ESP_AUX_CFG, ESP_SER_CTRL, ESP_BAUD_RELOAD,
                          ESP_SLV_ADDR, ESP_SLV_MASK, 8'h00};
  esp_serial_port uut (
    .clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer1_reload(8'hFE),
    .timer1_run(1'b1), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out)
  );
  esp_line_peer peer (.clk(clk), .txd(txd_out), .rxd(rxd_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // Register access and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(negedge clk);
    d = sfr_rdata;
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    results();
  end
  // ==========================================
  // Test sequence
  initial begin
    arst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(r_a[i], v);
      chk("reset value", (i == 0) ? 9'h010 : 9'h000, {1'b0, v});
    end
    for (i = 0; i < 8; i++) begin
      wr(ESP_BAUD_RELOAD, c_br[i]);
      wr(ESP_AUX_CFG, c_ax[i]);
      wr(ESP_PWR_CTRL, c_pc[i]);
      wr(ESP_SER_CTRL, c_sc[i]);
      repeat (300) @(posedge clk);
      peer.bit_clks = c_bit[i];
      peer.nine = c_sc[i][7];
      k = peer.n_got;
      fork
        wr(ESP_SER_BUF, 8'hA5);
        peer.send(9'h03C, 1'b1);
      join
      for (j = 0; j < 20000 && peer.n_got == k; j++) @(posedge clk);
      chk("tx seen", 9'(k + 1), 9'(peer.n_got));
      repeat (c_bit[i]) @(posedge clk);
      chk("tx frame", {c_sc[i][7], 8'hA5}, peer.got);
      chk("bit time", 9'(c_bit[i]), 9'(peer.start_len));
      rd(ESP_SER_CTRL, v);
      chk("flags", {1'b0, c_sc[i] | 8'h03 | (c_sc[i][7] ? 8'h00 : 8'h04)}, {1'b0, v});
      rd(ESP_SER_BUF, v);
      chk("rx data", 9'h03C, {1'b0, v});
    end
    wr(ESP_SLV_ADDR, 8'hC0);
    wr(ESP_SLV_MASK, 8'hFD);
    for (i = 0; i < 8; i++) begin
      wr(ESP_SER_CTRL, m_sc[i]);
      peer.nine = m_sc[i][7];
      peer.send(m_d[i], m_st[i]);
      repeat (48) @(posedge clk);
      rd(ESP_SER_CTRL, v);
      chk("address accept", {8'h00, m_ex[i]}, {8'h00, v[0]});
    end
    peer.nine = 1'b0;
    wr(ESP_PWR_CTRL, 8'hC0);
    wr(ESP_SER_CTRL, 8'h50);
    rd(ESP_SER_CTRL, v);
    chk("frame flag cleared", 9'h050, {1'b0, v});
    wr(ESP_PWR_CTRL, 8'h80);
    peer.send(9'h05A, 1'b0);
    repeat (48) @(posedge clk);
    rd(ESP_SER_CTRL, v);
    chk("mode bit shown", 9'h001, {1'b0, v & 8'h81});
    wr(ESP_PWR_CTRL, 8'hC0);
    rd(ESP_SER_CTRL, v);
    chk("frame flag shown", 9'h001, {8'h00, v[7]});
    peer.send(9'h033, 1'b1);
    repeat (48) @(posedge clk);
    rd(ESP_SER_BUF, v);
    chk("overrun keeps byte", 9'h05A, {1'b0, v});
    rd(ESP_SER_CTRL, v);
    chk("frame flag sticky", 9'h001, {8'h00, v[7]});
    peer.bit_clks = 0;
    for (i = 0; i < 2; i++) begin
      wr(ESP_AUX_CFG, i ? 8'h20 : 8'h00);
      wr(ESP_SER_CTRL, 8'h00);
      fork
        wr(ESP_SER_BUF, 8'h96);
        for (j = 0; j < 8; j++) begin
          @(negedge txd_out);
          s[j] = rxd_out;
          if (j == 0) begin
            t0 = $time;
            oe_seen = rxd_oe;
          end
        end
      join
      chk("shift data", 9'h096, {1'b0, s});
      chk("shift drive", 9'h001, {8'h00, oe_seen});
      chk("shift period", i ? 9'd14 : 9'd84, 9'(($time - t0) / 8));
      repeat (30) @(posedge clk);
      chk("shift release", 9'h000, {8'h00, rxd_oe});
    end
    results();
  end
endmodule : test_esp_serial_port
`default_nettype wire
